// *** stpc_pkg.sv ***
package stpc_pkg;

	localparam int STPC_CNT_W = 10;
	localparam int STPC_ADDR_W = 8;
	localparam int STPC_DATA_W = 32;

	// Register byte offsets.
	localparam logic [7:0] STPC_OFS_CTRL = 8'h00;
	localparam logic [7:0] STPC_OFS_COUNT = 8'h04;
	localparam logic [7:0] STPC_OFS_COMPARE_A_VALUE = 8'h08;
	localparam logic [7:0] STPC_OFS_COMPARE_P_VALUE = 8'h0C;
	localparam logic [7:0] STPC_OFS_STATUS = 8'h10;

	// Control register field positions.
	localparam int STPC_CTRL_MODE_LO = 0;
	localparam int STPC_CTRL_FUNC_LO = 2;
	localparam int STPC_CTRL_OC = 4;
	localparam int STPC_CTRL_POL = 5;
	localparam int STPC_CTRL_DPX = 6;
	localparam int STPC_CTRL_CCLR = 7;
	localparam int STPC_CTRL_RUN = 8;

	// Status register field positions, write one to clear.
	localparam int STPC_STAT_FLAG_A = 0;
	localparam int STPC_STAT_FLAG_P = 1;

	localparam logic [9:0] STPC_CNT_ZERO = 10'h000;
	localparam logic [9:0] STPC_CNT_ONE = 10'h001;
	localparam logic [31:0] STPC_WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		STPC_MODE_COMPARE = 2'h0,
		STPC_MODE_CAPTURE = 2'h1,
		STPC_MODE_PWM = 2'h2,
		STPC_MODE_TIMER = 2'h3
	} stpc_mode_type;

	// Pin function codes, meaning depends on the mode.
	localparam logic [1:0] STPC_FUNC_00 = 2'h0;
	localparam logic [1:0] STPC_FUNC_01 = 2'h1;
	localparam logic [1:0] STPC_FUNC_10 = 2'h2;
	localparam logic [1:0] STPC_FUNC_11 = 2'h3;

	typedef struct packed {
		stpc_mode_type mode_select;
		logic [1:0] pin_function;
		logic output_level_control;
		logic output_invert;
		logic duty_period_swap;
		logic clear_source_select;
	} stpc_ctrl_type;

	localparam stpc_ctrl_type STPC_CTRL_RESET = '{
		mode_select: STPC_MODE_COMPARE,
		pin_function: STPC_FUNC_00,
		output_level_control: 1'b0,
		output_invert: 1'b0,
		duty_period_swap: 1'b0,
		clear_source_select: 1'b0
	};

	typedef struct packed {
		logic [STPC_ADDR_W-1:0] addr;
		logic [STPC_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} stpc_bus_req_type;

endpackage : stpc_pkg

// *** stpc_sync.sv ***
`timescale 1ns/1ps
module stpc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} stpc_sync_type;

	stpc_sync_type s;
	stpc_sync_type next_s;

	// The first stage feeds only the second stage.
	always_comb begin
		next_s.first = async_i;
		next_s.second = s.first;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_o = s.second;
endmodule : stpc_sync

// *** stpc_edge.sv ***
`timescale 1ns/1ps
module stpc_edge (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic level_i,
	output logic rise_o,
	output logic fall_o
);
	typedef struct packed {
		logic last;
	} stpc_edge_type;

	stpc_edge_type s;
	stpc_edge_type next_s;

	always_comb begin
		next_s.last = level_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rise_o = level_i & ~s.last;
	assign fall_o = ~level_i & s.last;
endmodule : stpc_edge

// *** stpc_timer.sv ***
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module stpc_timer
	import stpc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [STPC_ADDR_W-1:0] reg_addr_i,
	input wire logic [STPC_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [STPC_DATA_W-1:0] reg_rdata_o,
	input wire logic external_trigger_pin_i,
	input wire logic capture_input_pin_i,
	output logic timer_out_o,
	output logic timer_out_active_o,
	output logic match_a_flag_o,
	output logic match_p_flag_o
);
	typedef struct packed {
		stpc_ctrl_type ctrl;
		logic counter_run_bit;
		logic run_last;
		logic [STPC_CNT_W-1:0] count;
		logic [STPC_CNT_W-1:0] compare_a_value;
		logic [STPC_CNT_W-1:0] compare_p_value;
		logic match_a_flag;
		logic match_p_flag;
		logic capture_pending;
		logic compare_level;
		logic pin;
		logic pin_active;
		logic [STPC_DATA_W-1:0] rdata;
	} stpc_state_type;

	stpc_state_type s;
	stpc_state_type next_s;
	stpc_bus_req_type req;

	logic [1:0] pins_sync;
	logic trig_rise;
	logic cap_rise;
	logic cap_fall;

	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i,
		rd: reg_rd_i};

	// External pins pass two flops before any logic sees them.
	stpc_sync #(
		.WIDTH(2)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i({capture_input_pin_i, external_trigger_pin_i}),
		.sync_o(pins_sync)
	);

	stpc_edge u_trig_edge (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.level_i(pins_sync[0]),
		.rise_o(trig_rise),
		.fall_o()
	);

	stpc_edge u_cap_edge (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.level_i(pins_sync[1]),
		.rise_o(cap_rise),
		.fall_o(cap_fall)
	);

	logic single_pulse;
	logic run_rise;
	logic counting;
	logic match_a;
	logic match_p;
	logic p_nonzero;
	logic a_nonzero;
	logic [STPC_CNT_W-1:0] pwm_period;
	logic [STPC_CNT_W-1:0] pwm_duty;
	logic pwm_wave;
	logic pin_act;
	logic cap_edge;
	logic clear_cnt;
	logic wr_ctrl;
	logic wr_stat;

	always_comb begin
		next_s = s;

		// The timer clock is the core clock, one count per edge.
		single_pulse = (s.ctrl.mode_select == STPC_MODE_PWM) &&
			(s.ctrl.pin_function == STPC_FUNC_11);
		run_rise = s.counter_run_bit & ~s.run_last;
		counting = s.counter_run_bit & s.run_last;
		match_a = counting && (s.count == s.compare_a_value);
		match_p = counting && (s.count == s.compare_p_value);
		p_nonzero = (s.compare_p_value != STPC_CNT_ZERO);
		a_nonzero = (s.compare_a_value != STPC_CNT_ZERO);
		clear_cnt = 1'b0;
		cap_edge = 1'b0;
		wr_ctrl = req.wr && (req.addr == STPC_OFS_CTRL);
		wr_stat = req.wr && (req.addr == STPC_OFS_STATUS);

		// Period register by swap bit; a zero period spans 1024 counts.
		pwm_period = s.ctrl.duty_period_swap ? s.compare_a_value :
			s.compare_p_value;
		pwm_duty = s.ctrl.duty_period_swap ? s.compare_p_value :
			s.compare_a_value;
		pwm_wave = (s.count < pwm_duty) ||
			((pwm_duty >= pwm_period) && (pwm_period != STPC_CNT_ZERO));

		next_s.run_last = s.counter_run_bit;
		next_s.capture_pending = 1'b0;

		// Status flags: write one clears, a new event wins below.
		if (wr_stat) begin
			if (req.wdata[STPC_STAT_FLAG_A]) begin
				next_s.match_a_flag = 1'b0;
			end
			if (req.wdata[STPC_STAT_FLAG_P]) begin
				next_s.match_p_flag = 1'b0;
			end
		end

		// Fields are placed one by one: a packed cast would reverse them.
		if (wr_ctrl) begin
			next_s.ctrl.mode_select = stpc_mode_type'(
				req.wdata[STPC_CTRL_MODE_LO +: $bits(stpc_mode_type)]);
			next_s.ctrl.pin_function =
				req.wdata[STPC_CTRL_FUNC_LO +: $bits(s.ctrl.pin_function)];
			next_s.ctrl.output_level_control = req.wdata[STPC_CTRL_OC];
			next_s.ctrl.output_invert = req.wdata[STPC_CTRL_POL];
			next_s.ctrl.duty_period_swap = req.wdata[STPC_CTRL_DPX];
			next_s.ctrl.clear_source_select = req.wdata[STPC_CTRL_CCLR];
			next_s.counter_run_bit = req.wdata[STPC_CTRL_RUN];
		end
		if (req.wr && (req.addr == STPC_OFS_COMPARE_A_VALUE)) begin
			next_s.compare_a_value = req.wdata[STPC_CNT_W-1:0];
		end
		if (req.wr && (req.addr == STPC_OFS_COMPARE_P_VALUE)) begin
			next_s.compare_p_value = req.wdata[STPC_CNT_W-1:0];
		end

		unique case (s.ctrl.mode_select)
			STPC_MODE_COMPARE, STPC_MODE_TIMER: begin
				if (s.ctrl.clear_source_select) begin
					clear_cnt = match_a;
				end else begin
					clear_cnt = match_p && p_nonzero;
					if (match_p && p_nonzero) begin
						next_s.match_p_flag = 1'b1;
					end
				end
				if (match_a && a_nonzero) begin
					next_s.match_a_flag = 1'b1;
					unique case (s.ctrl.pin_function)
						STPC_FUNC_00: next_s.compare_level = s.compare_level;
						STPC_FUNC_01: next_s.compare_level = 1'b0;
						STPC_FUNC_10: next_s.compare_level = 1'b1;
						STPC_FUNC_11: next_s.compare_level = ~s.compare_level;
					endcase
				end
				if (run_rise) begin
					next_s.compare_level = s.ctrl.output_level_control;
				end
			end
			STPC_MODE_CAPTURE: begin
				// Edge choice by pin function; 11 means no capture.
				unique case (s.ctrl.pin_function)
					STPC_FUNC_00: cap_edge = cap_rise;
					STPC_FUNC_01: cap_edge = cap_fall;
					STPC_FUNC_10: cap_edge = cap_rise | cap_fall;
					STPC_FUNC_11: cap_edge = 1'b0;
				endcase
				// A pulse shorter than one core clock can be lost at the first flop.
				if (cap_edge && s.counter_run_bit) begin
					next_s.compare_a_value = s.count;
					next_s.capture_pending = 1'b1;
				end
				// Compare P zero lets the counter wrap at its maximum.
				clear_cnt = match_p && p_nonzero;
				if (match_p && p_nonzero) begin
					next_s.match_p_flag = 1'b1;
				end
			end
			STPC_MODE_PWM: begin
				if (single_pulse) begin
					// Compare P, clear source and swap play no part here.
					if (trig_rise && !s.counter_run_bit) begin
						next_s.counter_run_bit = 1'b1;
					end
					if (match_a) begin
						next_s.counter_run_bit = 1'b0;
						next_s.match_a_flag = 1'b1;
					end
				end else begin
					// Period comes from the swap choice, not clear source.
					clear_cnt = counting &&
						(s.count == pwm_period - STPC_CNT_ONE);
					if (match_a) begin
						next_s.match_a_flag = 1'b1;
					end
					if (match_p) begin
						next_s.match_p_flag = 1'b1;
					end
				end
			end
		endcase

		// Latched value settles a cycle before the flag rises.
		if (s.capture_pending) begin
			next_s.match_a_flag = 1'b1;
		end

		// Counter zeroes on run rising, else counts while running.
		if (run_rise) begin
			next_s.count = STPC_CNT_ZERO;
		end else if (counting) begin
			if (clear_cnt) begin
				next_s.count = STPC_CNT_ZERO;
			end else begin
				next_s.count = s.count + STPC_CNT_ONE;
			end
		end

		// The wave runs inside; the function field picks what is shown.
		unique case (s.ctrl.pin_function)
			STPC_FUNC_00: pin_act = 1'b0;
			STPC_FUNC_01: pin_act = 1'b1;
			STPC_FUNC_10: pin_act = pwm_wave & s.counter_run_bit;
			STPC_FUNC_11: pin_act = s.counter_run_bit;
		endcase

		unique case (s.ctrl.mode_select)
			STPC_MODE_COMPARE: begin
				next_s.pin = s.compare_level ^ s.ctrl.output_invert;
				next_s.pin_active = 1'b1;
			end
			STPC_MODE_PWM: begin
				next_s.pin = (pin_act ? s.ctrl.output_level_control :
					~s.ctrl.output_level_control) ^ s.ctrl.output_invert;
				next_s.pin_active = 1'b1;
			end
			STPC_MODE_CAPTURE, STPC_MODE_TIMER: begin
				next_s.pin = 1'b0;
				next_s.pin_active = 1'b0;
			end
		endcase

		// Read data stand in the cycle after the strobe only.
		next_s.rdata = STPC_WORD_ZERO;
		if (req.rd) begin
			unique case (req.addr)
				STPC_OFS_CTRL: begin
					next_s.rdata[STPC_CTRL_MODE_LO +: $bits(stpc_mode_type)] =
						s.ctrl.mode_select;
					next_s.rdata[STPC_CTRL_FUNC_LO +: $bits(s.ctrl.pin_function)] =
						s.ctrl.pin_function;
					next_s.rdata[STPC_CTRL_OC] = s.ctrl.output_level_control;
					next_s.rdata[STPC_CTRL_POL] = s.ctrl.output_invert;
					next_s.rdata[STPC_CTRL_DPX] = s.ctrl.duty_period_swap;
					next_s.rdata[STPC_CTRL_CCLR] = s.ctrl.clear_source_select;
					next_s.rdata[STPC_CTRL_RUN] = s.counter_run_bit;
				end
				STPC_OFS_COUNT: next_s.rdata[STPC_CNT_W-1:0] = s.count;
				STPC_OFS_COMPARE_A_VALUE: next_s.rdata[STPC_CNT_W-1:0] = s.compare_a_value;
				STPC_OFS_COMPARE_P_VALUE: next_s.rdata[STPC_CNT_W-1:0] = s.compare_p_value;
				STPC_OFS_STATUS: begin
					next_s.rdata[STPC_STAT_FLAG_A] = s.match_a_flag;
					next_s.rdata[STPC_STAT_FLAG_P] = s.match_p_flag;
				end
				default: next_s.rdata = STPC_WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.ctrl <= STPC_CTRL_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata_o = s.rdata;
	assign timer_out_o = s.pin;
	assign timer_out_active_o = s.pin_active;
	assign match_a_flag_o = s.match_a_flag;
	assign match_p_flag_o = s.match_p_flag;
endmodule : stpc_timer

// *** stpc_timer_assertions.sv ***
`timescale 1ns/1ps
module stpc_timer_checker
	import stpc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [STPC_ADDR_W-1:0] reg_addr_i,
	input wire logic [STPC_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [STPC_DATA_W-1:0] reg_rdata_o,
	input wire logic external_trigger_pin_i,
	input wire logic timer_out_o,
	input wire logic timer_out_active_o,
	input wire logic match_a_flag_o,
	input wire logic match_p_flag_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Mode shadow is trusted only three cycles after a control write.
	logic [5:0] ctl;
	logic [1:0] age;
	logic ctl_wr;
	logic sp;
	logic cap;
	logic clr_a;
	logic clr_p;
	assign ctl_wr = reg_wr_i && reg_addr_i == STPC_OFS_CTRL;
	assign sp = age == 2'h3 && ctl[3:0] == 4'hE;
	assign cap = age == 2'h3 && ctl[1:0] == 2'h1;
	assign clr_a = reg_wr_i && reg_addr_i == STPC_OFS_STATUS && reg_wdata_i[0];
	assign clr_p = reg_wr_i && reg_addr_i == STPC_OFS_STATUS && reg_wdata_i[1];
	always_ff @(posedge core_clk_i) begin
		if (rst_i || ctl_wr) begin
			ctl <= rst_i ? 6'h00 : reg_wdata_i[5:0];
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	sequence s_pulse_ends;
		sp && $rose(match_a_flag_o);
	endsequence
	sequence s_trigger_idle;
		sp && ctl[4] && !ctl[5] && !timer_out_o ##1 $rose(external_trigger_pin_i);
	endsequence
	a_read_idle_zero: assert property (
		!reg_rd_i |=> reg_rdata_o == STPC_WORD_ZERO)
		else $error("read data not zero outside a read");
	a_flag_a_sticky: assert property (
		match_a_flag_o && !clr_a |=> match_a_flag_o)
		else $error("flag A dropped without a clear");
	a_flag_p_sticky: assert property (
		match_p_flag_o && !clr_p |=> match_p_flag_o)
		else $error("flag P dropped without a clear");
	a_pulse_match_end: assert property (
		s_pulse_ends |-> ##[0:2] timer_out_o == (!ctl[4] ^ ctl[5]))
		else $error("pulse did not end after match A");
	a_trigger_starts: assert property (
		s_trigger_idle |-> ##[1:6] timer_out_o)
		else $error("trigger pin did not start the pulse");
	a_pulse_drives_pin: assert property (sp |-> timer_out_active_o)
		else $error("single pulse mode not driving the pin");
	a_capture_no_out: assert property (
		cap |-> !timer_out_active_o && !timer_out_o)
		else $error("capture mode drives the pin");
	a_capture_off: assert property (
		cap && ctl[3:2] == 2'h3 |-> !$rose(match_a_flag_o))
		else $error("capture happened while disabled");
	a_pwm_forced: assert property (
		age == 2'h3 && ctl[1:0] == 2'h2 && !ctl[3]
		|-> timer_out_o == ((ctl[2] ~^ ctl[4]) ^ ctl[5]))
		else $error("forced PWM level wrong");
	a_pulse_no_p: assert property (sp |-> !$rose(match_p_flag_o))
		else $error("flag P set in single pulse mode");
endmodule : stpc_timer_checker

// *** stpc_pin_model.sv ***
`timescale 1ns/1ps
module stpc_pin_model (
	input wire logic core_clk_i,
	output logic external_trigger_pin_o,
	output logic capture_input_pin_o
);
	initial begin
		external_trigger_pin_o = 1'b0;
		capture_input_pin_o = 1'b0;
	end
	// Levels are held well over two timer clocks so no edge may be dropped.
	task automatic set_capture(input logic v);
		@(posedge core_clk_i);
		capture_input_pin_o <= v;
		repeat (6) @(posedge core_clk_i);
	endtask : set_capture
	task automatic trigger();
		@(posedge core_clk_i);
		external_trigger_pin_o <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		external_trigger_pin_o <= 1'b0;
	endtask : trigger
endmodule : stpc_pin_model

// *** test_timer_single_pulse_capture.sv ***
`timescale 1ns/1ps
module test_timer_single_pulse_capture;
	import stpc_pkg::*;
	logic core_clk_i, rst_i, reg_wr_i, reg_rd_i, trig, capin;
	logic tout, tact, fa, fp;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, d, v;
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int n;
	stpc_timer stpc_timer_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.external_trigger_pin_i(trig), .capture_input_pin_i(capin),
		.timer_out_o(tout), .timer_out_active_o(tact),
		.match_a_flag_o(fa), .match_p_flag_o(fp));
	stpc_pin_model stpc_pin_model_inst (.core_clk_i(core_clk_i),
		.external_trigger_pin_o(trig), .capture_input_pin_o(capin));
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= w;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd
	task automatic rdck(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask : rdck
	task automatic wait_out(input logic lv);
		n = 0;
		while (tout !== lv && n < 40) begin
			@(posedge core_clk_i);
			#1 n++;
		end
		chk(32'(tout), 32'(lv));
	endtask : wait_out
	task automatic t_regs();
		rdck(STPC_OFS_CTRL, 32'h0);
		rdck(STPC_OFS_COMPARE_A_VALUE, 32'h0);
		wr(STPC_OFS_COMPARE_P_VALUE, 32'hFFFF_FFFF);
		rdck(STPC_OFS_COMPARE_P_VALUE, 32'h0000_03FF);
		wr(STPC_OFS_COUNT, 32'h0000_0155);
		rdck(STPC_OFS_COUNT, 32'h0);
		wr(8'h40, 32'h0000_0155);
		rdck(8'h40, 32'h0);
	endtask : t_regs
	task automatic t_sp_soft();
		wr(STPC_OFS_COMPARE_A_VALUE, 32'h0000_000A);
		wr(STPC_OFS_CTRL, 32'h0000_011E);
		wait_out(1'b1);
		chk(32'(tact), 32'h1);
		n = 0;
		while (tout === 1'b1 && n < 40) begin
			@(posedge core_clk_i);
			#1 n++;
		end
		chk(32'(n >= 10 && n <= 14), 32'h1);
		chk(32'(fa), 32'h1);
		chk(32'(fp), 32'h0);
		rdck(STPC_OFS_STATUS, 32'h1);
		rdck(STPC_OFS_CTRL, 32'h0000_001E);
		rd(STPC_OFS_COUNT);
		v = d;
		rdck(STPC_OFS_COUNT, v);
		wr(STPC_OFS_STATUS, 32'h1);
		rdck(STPC_OFS_STATUS, 32'h0);
	endtask : t_sp_soft
	task automatic t_sp_trig();
		stpc_pin_model_inst.trigger();
		wait_out(1'b1);
		wait_out(1'b0);
		rdck(STPC_OFS_COUNT, v);
		wr(STPC_OFS_STATUS, 32'h1);
		wr(STPC_OFS_COMPARE_A_VALUE, 32'h0000_03FF);
		wr(STPC_OFS_CTRL, 32'h0000_011E);
		wait_out(1'b1);
		wr(STPC_OFS_CTRL, 32'h0000_001E);
		wait_out(1'b0);
		rdck(STPC_OFS_STATUS, 32'h0);
	endtask : t_sp_trig
	task automatic t_capture();
		wr(STPC_OFS_COMPARE_P_VALUE, 32'h0);
		for (int f = 0; f < 4; f++) begin
			wr(STPC_OFS_CTRL, 32'h0000_0101 | (f << 2));
			wr(STPC_OFS_STATUS, 32'h1);
			stpc_pin_model_inst.set_capture(1'b1);
			rdck(STPC_OFS_STATUS, 32'(f == 0 || f == 2));
			wr(STPC_OFS_STATUS, 32'h1);
			stpc_pin_model_inst.set_capture(1'b0);
			rdck(STPC_OFS_STATUS, 32'(f == 1 || f == 2));
		end
		chk(32'(tact), 32'h0);
		rd(STPC_OFS_COMPARE_A_VALUE);
		v = d;
		rd(STPC_OFS_COUNT);
		chk(32'(d > v && v != 0), 32'h1);
		wr(STPC_OFS_CTRL, 32'h0000_000D);
		rd(STPC_OFS_COUNT);
		v = d;
		rdck(STPC_OFS_COUNT, v);
		wr(STPC_OFS_COMPARE_P_VALUE, 32'h0000_0014);
		wr(STPC_OFS_CTRL, 32'h0000_010D);
		repeat (30) @(posedge core_clk_i);
		#1 chk(32'(fp), 32'h1);
		rdck(STPC_OFS_STATUS, 32'h2);
		rd(STPC_OFS_COUNT);
		chk(32'(d <= 32'h14), 32'h1);
	endtask : t_capture
	task automatic t_pwm();
		for (int f = 0; f < 2; f++) begin
			wr(STPC_OFS_CTRL, 32'h0000_0112 | (f << 2));
			repeat (4) @(posedge core_clk_i);
			#1 chk(32'(tout), 32'(f));
		end
	endtask : t_pwm
	initial begin
		rst_i = 1'b1;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_sp_soft();
		t_sp_trig();
		t_capture();
		t_pwm();
		final_report();
	end
endmodule : test_timer_single_pulse_capture
bind stpc_timer stpc_timer_checker stpc_timer_checker_inst (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .external_trigger_pin_i(external_trigger_pin_i),
	.timer_out_o(timer_out_o), .timer_out_active_o(timer_out_active_o),
	.match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o));
